/* logic/pfs_pkg.sv */
// timing and sizing constants for the pwm fault sequencer
// assumes a single 100 MHz core clock
package pfs_pkg;

   // ----------------------------------------------------------------
   // clock
   // ----------------------------------------------------------------
   localparam int unsigned CLK_KHZ = 100000;

   // ----------------------------------------------------------------
   // oscillator
   // ----------------------------------------------------------------
   localparam int unsigned OSC_K_KHZ_KOHM = 1300;
   localparam int unsigned BURST_KHZ = 22;
   localparam int unsigned BURST_PER_CYC = CLK_KHZ / BURST_KHZ;
   localparam int unsigned SHUF_HZ = 32;
   localparam int unsigned SHUF_PCT = 4;
   localparam int unsigned SHUF_SPAN = 16;
   localparam int unsigned SHUF_STEPS = 4 * SHUF_SPAN;
   localparam int unsigned SHUF_STEP_CYC =
      (CLK_KHZ * 1000) / (SHUF_HZ * SHUF_STEPS);

   // ----------------------------------------------------------------
   // pulse timing
   // ----------------------------------------------------------------
   localparam int unsigned BLANK_NS = 300;
   localparam int unsigned BLANK_CYC = (BLANK_NS * CLK_KHZ + 999999) / 1000000;
   localparam int unsigned SS_MS = 4;
   localparam int unsigned SS_STEPS = 256;
   localparam int unsigned SS_STEP_CYC = (SS_MS * CLK_KHZ) / SS_STEPS;

   // ----------------------------------------------------------------
   // fault debounce and restart
   // ----------------------------------------------------------------
   localparam int unsigned BO_DEB_MS = 50;
   localparam int unsigned BO_DEB_CYC = BO_DEB_MS * CLK_KHZ;
   localparam int unsigned OLP_DEB_MS = 250;
   localparam int unsigned OLP_DEB_CYC = OLP_DEB_MS * CLK_KHZ + 1;
   localparam int unsigned RESTART_MS = 1000;
   localparam int unsigned RESTART_CYC = RESTART_MS * CLK_KHZ;
   localparam int unsigned CNT_W = 27;

endpackage

/* logic/pfs_ctl_if.sv */
// links the sequencer core to its oscillator and soft-start ramp
// assumes all three run on the same clock
`timescale 1ns/1ns
`default_nettype none
interface pfs_ctl_if;
   logic [5:0] ri_kohm;
   logic burst;
   logic cyc_start;
   logic duty_ok;
   logic ss_hold;
   logic [7:0] ss_level;

   modport osc (input ri_kohm, input burst, output cyc_start, output duty_ok);
   modport ss (input ss_hold, output ss_level);
   modport ctl (output ri_kohm, output burst, output ss_hold,
                input cyc_start, input duty_ok, input ss_level);
endinterface
`default_nettype wire

/* logic/pfs_osc.sv */
// switching oscillator with triangular frequency shuffle
// assumes ri_kohm is a static setting from the core
`timescale 1ns/1ns
`default_nettype none
module pfs_osc #(
   parameter int unsigned SHUF_STEP_CYC = pfs_pkg::SHUF_STEP_CYC
) (
   input wire logic clock,
   input wire logic rst_b,
   pfs_ctl_if.osc bus
);
   logic [15:0] cnt_reg, cnt_next, per_reg, per_next;
   logic signed [5:0] tri_reg, tri_next;
   logic dir_reg, dir_next;
   logic [23:0] step_reg, step_next;
   logic [31:0] nom;
   logic signed [31:0] adj;

   always_comb
   begin
      nom = (32'(pfs_pkg::CLK_KHZ) * 32'(bus.ri_kohm))
            / 32'(pfs_pkg::OSC_K_KHZ_KOHM);
      if (bus.burst)
         nom = 32'(pfs_pkg::BURST_PER_CYC);
      adj = (signed'(nom) * 32'(tri_reg) * signed'(32'(pfs_pkg::SHUF_PCT)))
            / signed'(32'(100 * pfs_pkg::SHUF_SPAN));
      step_next = step_reg + 24'h000001;
      tri_next = tri_reg;
      dir_next = dir_reg;
      if (step_reg >= 24'(SHUF_STEP_CYC - 1))
      begin
         step_next = 24'h000000;
         if (dir_reg)
            tri_next = tri_reg + 6'sh01;
         else
            tri_next = tri_reg - 6'sh01;
         if (tri_next == 6'(pfs_pkg::SHUF_SPAN))
            dir_next = 1'b0;
         if (tri_next == -6'sh10)
            dir_next = 1'b1;
      end
      cnt_next = cnt_reg - 16'h0001;
      per_next = per_reg;
      if (cnt_reg == 16'h0000)
      begin
         per_next = 16'(signed'(nom) + adj);
         if (per_next < 16'h0004)
            per_next = 16'h0004;
         cnt_next = per_next - 16'h0001;
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt_reg <= 16'h0000;
         per_reg <= 16'h0004;
         tri_reg <= 6'sh00;
         dir_reg <= 1'b1;
         step_reg <= 24'h000000;
      end
      else
      begin
         cnt_reg <= cnt_next;
         per_reg <= per_next;
         tri_reg <= tri_next;
         dir_reg <= dir_next;
         step_reg <= step_next;
      end
   end

   assign bus.cyc_start = (cnt_reg == 16'h0000);
   // first half of each period only: duty limit
   assign bus.duty_ok = (cnt_reg >= {1'b0, per_reg[15:1]});
endmodule
`default_nettype wire

/* logic/pfs_ss.sv */
// soft-start ramp of the on-time ceiling
// assumes ss_hold is high whenever switching is blocked
`timescale 1ns/1ns
`default_nettype none
module pfs_ss (
   input wire logic clock,
   input wire logic rst_b,
   pfs_ctl_if.ss bus
);
   logic [7:0] lvl_reg, lvl_next;
   logic [11:0] cnt_reg, cnt_next;

   always_comb
   begin
      lvl_next = lvl_reg;
      cnt_next = cnt_reg + 12'h001;
      if (bus.ss_hold)
      begin
         lvl_next = 8'h00;
         cnt_next = 12'h000;
      end
      else if (cnt_reg >= 12'(pfs_pkg::SS_STEP_CYC - 1))
      begin
         cnt_next = 12'h000;
         if (lvl_reg != 8'hff)
            lvl_next = lvl_reg + 8'h01;
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lvl_reg <= 8'h00;
         cnt_reg <= 12'h000;
      end
      else
      begin
         lvl_reg <= lvl_next;
         cnt_reg <= cnt_next;
      end
   end

   assign bus.ss_level = lvl_reg;
endmodule
`default_nettype wire

/* logic/pfs_seq.sv */
// pwm fault sequencer: gate command, burst gating and protections
// assumes comparator results arrive asynchronous; reset from supply lockout
`timescale 1ns/1ns
`default_nettype none
module pfs_seq #(
   parameter int unsigned BO_DEB_CYC = pfs_pkg::BO_DEB_CYC,
   parameter int unsigned OLP_DEB_CYC = pfs_pkg::OLP_DEB_CYC,
   parameter int unsigned RESTART_CYC = pfs_pkg::RESTART_CYC,
   parameter int unsigned SHUF_STEP_CYC = pfs_pkg::SHUF_STEP_CYC
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic fb_below_burst,
   input wire logic supply_below_preset,
   input wire logic fb_on_request,
   input wire logic sense_trip,
   input wire logic ilim_trip,
   input wire logic temp_below_otp,
   input wire logic otp_latch_mode,
   input wire logic line_below_bo,
   input wire logic overload_detect,
   input wire logic ri_float,
   input wire logic sense_float,
   input wire logic fb_float,
   input wire logic ri_short,
   input wire logic supply_below_release,
   input wire logic undervoltage_lockout_active,
   input wire logic [5:0] ri_kohm,
   output logic switch_drive,
   output logic burst_active,
   output logic overtemp_fault,
   output logic latch_shutdown,
   output logic brownout_fault,
   output logic overload_fault,
   output logic pin_fault
);
   // ----------------------------------------------------------------
   // types and helpers
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_RUN = 2'b01,
      ST_OLP = 2'b10,
      ST_LATCH = 2'b11
   } pfs_state_e;

   localparam int unsigned NSYNC = 21;
   localparam int unsigned CW = pfs_pkg::CNT_W;

   // saturating count toward a limit
   function automatic logic [CW-1:0] sat_inc(
      input logic [CW-1:0] cnt,
      input logic [CW-1:0] lim
   );
      if (cnt >= lim)
         return lim;
      else
         return cnt + 1'b1;
   endfunction

   // ----------------------------------------------------------------
   // input synchroniser
   // ----------------------------------------------------------------
   logic [NSYNC-1:0] raw;
   logic [NSYNC-1:0] sy1_reg, sy2_reg;

   assign raw = {ri_kohm, undervoltage_lockout_active, supply_below_release, ri_short,
                 fb_float, sense_float, ri_float, overload_detect,
                 line_below_bo, otp_latch_mode, temp_below_otp, ilim_trip,
                 sense_trip, fb_on_request, supply_below_preset,
                 fb_below_burst};

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sy1_reg <= '0;
         sy2_reg <= '0;
      end
      else
      begin
         sy1_reg <= raw;
         sy2_reg <= sy1_reg;
      end
   end

   logic s_burst, s_low_sup, s_on_req, s_sense, s_ilim, s_temp, s_latch_mode;
   logic s_line, s_ovl, s_pin, s_release, s_undervoltage_lockout;

   assign s_burst = sy2_reg[0];
   assign s_low_sup = sy2_reg[1];
   assign s_on_req = sy2_reg[2];
   assign s_sense = sy2_reg[3];
   assign s_ilim = sy2_reg[4];
   assign s_temp = sy2_reg[5];
   assign s_latch_mode = sy2_reg[6];
   assign s_line = sy2_reg[7];
   assign s_ovl = sy2_reg[8];
   assign s_pin = |sy2_reg[12:9];
   assign s_release = sy2_reg[13];
   assign s_undervoltage_lockout = sy2_reg[14];

   // static resistor word, taken once two samples agree
   logic [5:0] ri3_reg, ri_reg, ri_next;

   assign ri_next = (sy2_reg[20:15] == ri3_reg) ? ri3_reg : ri_reg;

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ri3_reg <= 6'h00;
         ri_reg <= 6'h00;
      end
      else
      begin
         ri3_reg <= sy2_reg[20:15];
         ri_reg <= ri_next;
      end
   end

   // ----------------------------------------------------------------
   // sub-blocks
   // ----------------------------------------------------------------
   pfs_ctl_if ctl ();

   pfs_osc #(
      .SHUF_STEP_CYC(SHUF_STEP_CYC)
   ) u_osc (
      .clock(clock),
      .rst_b(rst_b),
      .bus(ctl.osc)
   );

   pfs_ss u_ss (
      .clock(clock),
      .rst_b(rst_b),
      .bus(ctl.ss)
   );

   // ----------------------------------------------------------------
   // fault sequencing
   // ----------------------------------------------------------------
   pfs_state_e st_reg, st_next;
   logic [CW-1:0] bo_reg, bo_next;
   logic [CW-1:0] olp_reg, olp_next;
   logic [CW-1:0] rst_cnt_reg, rst_cnt_next;
   logic latch_set, bo_hit, olp_hit, otp_auto, blocked;

   assign latch_set = s_temp & s_latch_mode;
   // auto mode blocks only while present
   assign otp_auto = s_temp & ~s_latch_mode;
   // line low for the debounce time
   assign bo_hit = (bo_reg >= CW'(BO_DEB_CYC));
   assign olp_hit = (olp_reg >= CW'(OLP_DEB_CYC));

   always_comb
   begin
      st_next = st_reg;
      bo_next = '0;
      olp_next = '0;
      rst_cnt_next = '0;
      if (s_line)
         bo_next = sat_inc(bo_reg, CW'(BO_DEB_CYC));
      unique case (st_reg)
         ST_OFF:
         begin
            if (latch_set)
               st_next = ST_LATCH;
            else if (!s_undervoltage_lockout)
               st_next = ST_RUN;
         end
         ST_RUN:
         begin
            if (s_ovl)
               olp_next = sat_inc(olp_reg, CW'(OLP_DEB_CYC));
            if (latch_set)
               st_next = ST_LATCH;
            else if (s_undervoltage_lockout)
               st_next = ST_OFF;
            else if (olp_hit)
               st_next = ST_OLP;
         end
         ST_OLP:
         begin
            rst_cnt_next = sat_inc(rst_cnt_reg, CW'(RESTART_CYC));
            if (latch_set)
               st_next = ST_LATCH;
            // each overload entry gets a full period
            else if (rst_cnt_reg >= CW'(RESTART_CYC - 1))
            begin
               if (s_undervoltage_lockout)
                  st_next = ST_OFF;
               else
                  st_next = ST_RUN;
            end
         end
         ST_LATCH:
         begin
            // release only on low supply, set wins
            if (s_release && !latch_set)
               st_next = ST_OFF;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_reg <= ST_OFF;
         bo_reg <= '0;
         olp_reg <= '0;
         rst_cnt_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
         bo_reg <= bo_next;
         olp_reg <= olp_next;
         rst_cnt_reg <= rst_cnt_next;
      end
   end

   assign blocked = (st_reg != ST_RUN) | s_undervoltage_lockout | otp_auto | latch_set
                    | bo_hit | s_pin;

   // ----------------------------------------------------------------
   // gate pulse generation
   // ----------------------------------------------------------------
   logic pulse_en;
   logic gate_reg, gate_next;
   logic [11:0] on_reg, on_next;
   logic blank_over, ss_limit;
   logic [11:0] ss_cap;

   assign ctl.burst = s_burst;
   assign ctl.ri_kohm = ri_reg;
   assign ctl.ss_hold = blocked;
   assign pulse_en = ~s_burst | (s_low_sup & s_on_req);
   assign blank_over = (on_reg >= 12'(pfs_pkg::BLANK_CYC));
   assign ss_cap = {ctl.ss_level, 4'h0};
   assign ss_limit = (on_reg >= ss_cap);

   always_comb
   begin
      gate_next = 1'b0;
      on_next = 12'h000;
      // off whenever burst enable is missing
      if (blocked || !pulse_en)
         gate_next = 1'b0;
      else if (gate_reg)
      begin
         gate_next = 1'b1;
         on_next = on_reg + 12'h001;
         if (!ctl.duty_ok || ss_limit)
            gate_next = 1'b0;
         // sense or limit trip ends on-time
         if (blank_over && (s_sense || s_ilim))
            gate_next = 1'b0;
         if (!gate_next)
            on_next = 12'h000;
      end
      else if (ctl.cyc_start && ctl.ss_level != 8'h00)
      begin
         gate_next = 1'b1;
         on_next = 12'h001;
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         gate_reg <= 1'b0;
         on_reg <= 12'h000;
      end
      else
      begin
         gate_reg <= gate_next;
         on_reg <= on_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   logic ot_reg, bu_reg, bo_out_reg, pin_reg;

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ot_reg <= 1'b0;
         bu_reg <= 1'b0;
         bo_out_reg <= 1'b0;
         pin_reg <= 1'b0;
      end
      else
      begin
         ot_reg <= s_temp;
         bu_reg <= s_burst;
         bo_out_reg <= bo_hit;
         pin_reg <= s_pin;
      end
   end

   assign switch_drive = gate_reg;
   assign overtemp_fault = ot_reg;
   assign burst_active = bu_reg;
   assign brownout_fault = bo_out_reg;
   assign pin_fault = pin_reg;
   assign latch_shutdown = (st_reg == ST_LATCH);
   assign overload_fault = (st_reg == ST_OLP);
endmodule
`default_nettype wire

/* tb/pfs_seq_checker.sv */
// port checker for the pwm fault sequencer, bound to its top
// assumes inputs are quiet while reset is low
`timescale 1ns/1ns
`default_nettype none
module pfs_seq_checker #(
   parameter int unsigned BO_DEB_CYC = 50,
   parameter int unsigned RESTART_CYC = 100
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic fb_below_burst,
   input wire logic supply_below_preset,
   input wire logic temp_below_otp,
   input wire logic line_below_bo,
   input wire logic ri_float,
   input wire logic sense_float,
   input wire logic fb_float,
   input wire logic ri_short,
   input wire logic supply_below_release,
   input wire logic undervoltage_lockout_active,
   input wire logic switch_drive,
   input wire logic burst_active,
   input wire logic overtemp_fault,
   input wire logic latch_shutdown,
   input wire logic brownout_fault,
   input wire logic overload_fault,
   input wire logic pin_fault
);
   // ----------------------------------------------------------------
   // run-length counters
   // ----------------------------------------------------------------
   logic any_pin;
   logic [31:0] olp_len_reg, olp_len_next, bo_len_reg, bo_len_next;
   assign any_pin = ri_float | sense_float | fb_float | ri_short;
   always_comb
   begin
      olp_len_next = overload_fault ? olp_len_reg + 32'h1 : 32'h0;
      bo_len_next = line_below_bo ? bo_len_reg + 32'h1 : 32'h0;
   end
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         olp_len_reg <= 32'h0;
         bo_len_reg <= 32'h0;
      end
      else
      begin
         olp_len_reg <= olp_len_next;
         bo_len_reg <= bo_len_next;
      end
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   property p_ot;
      temp_below_otp |-> ##3 overtemp_fault;
   endproperty
   a_ot: assert property (p_ot) else $error("overtemp flag late");
   property p_pin;
      1'b1 |-> ##3 (pin_fault == $past(any_pin, 3));
   endproperty
   a_pin: assert property (p_pin) else $error("pin flag wrong");
   property p_burst;
      fb_below_burst |-> ##3 burst_active;
   endproperty
   a_burst: assert property (p_burst) else $error("no burst");
   property p_bgate;
      fb_below_burst && !supply_below_preset |-> ##3 !switch_drive;
   endproperty
   a_bgate: assert property (p_bgate) else $error("burst gate on");
   property p_block;
      temp_below_otp || any_pin || undervoltage_lockout_active |-> ##3 !switch_drive;
   endproperty
   a_block: assert property (p_block) else $error("gate not off");
   property p_hold;
      latch_shutdown && !supply_below_release
         && !$past(supply_below_release)
         && !$past(supply_below_release, 2) |=> latch_shutdown;
   endproperty
   a_hold: assert property (p_hold) else $error("latch lost");
   property p_lgate;
      latch_shutdown |-> !switch_drive;
   endproperty
   a_lgate: assert property (p_lgate) else $error("gate in latch");
   property p_ogate;
      overload_fault |=> !switch_drive;
   endproperty
   a_ogate: assert property (p_ogate) else $error("gate in olp");
   property p_olen;
      $fell(overload_fault) && !latch_shutdown |->
         olp_len_reg == RESTART_CYC;
   endproperty
   a_olen: assert property (p_olen) else $error("restart time");
   property p_bo;
      bo_len_reg > BO_DEB_CYC + 32'h4 |-> brownout_fault;
   endproperty
   a_bo: assert property (p_bo) else $error("brownout late");
   c_pulse: cover property ($rose(switch_drive));
   c_latch: cover property ($rose(latch_shutdown));
   c_olp: cover property ($fell(overload_fault));
   c_bo: cover property ($rose(brownout_fault));
endmodule
bind pfs_seq pfs_seq_checker #(.BO_DEB_CYC(BO_DEB_CYC),
   .RESTART_CYC(RESTART_CYC)) u_pfs_seq_checker (
   .clock(clock), .rst_b(rst_b), .fb_below_burst(fb_below_burst),
   .supply_below_preset(supply_below_preset),
   .temp_below_otp(temp_below_otp), .line_below_bo(line_below_bo),
   .ri_float(ri_float), .sense_float(sense_float),
   .fb_float(fb_float), .ri_short(ri_short),
   .supply_below_release(supply_below_release),
   .undervoltage_lockout_active(undervoltage_lockout_active), .switch_drive(switch_drive),
   .burst_active(burst_active), .overtemp_fault(overtemp_fault),
   .latch_shutdown(latch_shutdown), .brownout_fault(brownout_fault),
   .overload_fault(overload_fault), .pin_fault(pin_fault));
`default_nettype wire

/* tb/pfs_power_stage.sv */
// power switch and sense network: current ramps while gate is on
// assumes trip points are set by the bench
`timescale 1ns/1ns
`default_nettype none
module pfs_power_stage (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic switch_drive,
   input wire logic [15:0] sense_at,
   input wire logic [15:0] ilim_at,
   output logic sense_trip,
   output logic ilim_trip
);
   logic [15:0] on_cnt;
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         on_cnt <= 16'h0;
      else if (switch_drive)
         on_cnt <= on_cnt + 16'h1;
      else
         on_cnt <= 16'h0;
   end
   // no current while the switch is off
   assign sense_trip = switch_drive && (on_cnt >= sense_at);
   assign ilim_trip = switch_drive && (on_cnt >= ilim_at);
endmodule
`default_nettype wire

/* tb/pfs_seq_test.sv */
// self-checking bench for the pwm fault sequencer
// assumes shortened debounce and restart counts on the top
`timescale 1ns/1ns
`default_nettype none
module pfs_seq_test;
   localparam int BO = 50;
   localparam int OVERLOAD_FAULT = 40;
   localparam int RST = 100;
   localparam int BLANK = int'(pfs_pkg::BLANK_CYC);
   localparam int SS = int'(pfs_pkg::SS_STEP_CYC);
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic fb_below_burst = 1'b0, supply_below_preset = 1'b0;
   logic fb_on_request = 1'b0, temp_below_otp = 1'b0;
   logic otp_latch_mode = 1'b0, line_below_bo = 1'b0;
   logic overload_detect = 1'b0, supply_below_release = 1'b0;
   logic undervoltage_lockout_active = 1'b1;
   logic [3:0] pins = 4'h0;
   logic [5:0] ri_kohm = 6'h03;
   logic [15:0] sense_at = 16'hffff, ilim_at = 16'hffff;
   logic sense_trip, ilim_trip, switch_drive, burst_active;
   logic overtemp_fault, latch_shutdown, brownout_fault;
   logic overload_fault, pin_fault;
   logic [31:0] seed = 32'h519e;
   int error_cnt = 0;
   int compares = 0;
   int cyc_cnt = 0;
   always #5 clock = ~clock;
   pfs_seq #(.BO_DEB_CYC(BO), .OLP_DEB_CYC(OVERLOAD_FAULT), .RESTART_CYC(RST),
      .SHUF_STEP_CYC(8)) u_pfs_seq (
      .clock(clock), .rst_b(rst_b), .fb_below_burst(fb_below_burst),
      .supply_below_preset(supply_below_preset),
      .fb_on_request(fb_on_request), .sense_trip(sense_trip),
      .ilim_trip(ilim_trip), .temp_below_otp(temp_below_otp),
      .otp_latch_mode(otp_latch_mode), .line_below_bo(line_below_bo),
      .overload_detect(overload_detect), .ri_float(pins[0]),
      .sense_float(pins[1]), .fb_float(pins[2]), .ri_short(pins[3]),
      .supply_below_release(supply_below_release),
      .undervoltage_lockout_active(undervoltage_lockout_active), .ri_kohm(ri_kohm),
      .switch_drive(switch_drive), .burst_active(burst_active),
      .overtemp_fault(overtemp_fault), .latch_shutdown(latch_shutdown),
      .brownout_fault(brownout_fault), .overload_fault(overload_fault),
      .pin_fault(pin_fault));
   pfs_power_stage u_pfs_power_stage (.clock(clock), .rst_b(rst_b),
      .switch_drive(switch_drive), .sense_at(sense_at),
      .ilim_at(ilim_at), .sense_trip(sense_trip), .ilim_trip(ilim_trip));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [31:0] inr(input int v, input int lo,
      input int hi);
      return {31'h0, v >= lo && v <= hi};
   endfunction
   function automatic logic [31:0] near(input int v, input int nom);
      return inr(v, nom - nom * 4 / 100 - 2, nom + nom * 4 / 100 + 2);
   endfunction
   function automatic int per(input int r);
      return r * int'(pfs_pkg::CLK_KHZ) / int'(pfs_pkg::OSC_K_KHZ_KOHM);
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic next_rise(input int lim, output int n);
      n = 0;
      while (switch_drive !== 1'b0 && n < lim)
      begin
         @(negedge clock);
         n++;
      end
      while (switch_drive !== 1'b1 && n < lim)
      begin
         @(negedge clock);
         n++;
      end
   endtask
   task automatic high_len(output int n);
      n = 0;
      while (switch_drive === 1'b1 && n < 5000)
      begin
         @(negedge clock);
         n++;
      end
   endtask
   task automatic rises(input int lim, output int n);
      logic p;
      p = switch_drive;
      n = 0;
      repeat (lim)
      begin
         @(negedge clock);
         if (switch_drive === 1'b1 && p !== 1'b1)
            n++;
         p = switch_drive;
      end
   endtask
   task automatic olp_wait(input logic v, output int n);
      n = 0;
      while (overload_fault !== v && n < 500)
      begin
         @(negedge clock);
         n++;
      end
   endtask
   task automatic done(input string s);
      $display("test %s done", s);
      @(posedge clock);
   endtask
   task automatic tally_and_finish();
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clock)
   begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 95000)
      begin
         error_cnt++;
         tally_and_finish();
      end
   end
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial
   begin
      int n, t, lo;
      repeat (3) @(posedge clock);
      check({25'h0, switch_drive, burst_active, overtemp_fault,
         latch_shutdown, brownout_fault, overload_fault, pin_fault}, 0);
      rst_b <= 1'b1;
      @(posedge clock);
      undervoltage_lockout_active <= 1'b0;
      next_rise(20000, n);
      check(inr(n, SS, SS + 400), 32'h1);
      cyc(14000);
      done("soft start");
      for (int k = 0; k < 4; k++)
      begin
         seed = xs(seed);
         t = (k < 2) ? 5 : 40 + int'(seed[3:0]);
         @(posedge clock);
         sense_at <= k[0] ? 16'(t) : 16'hffff;
         ilim_at <= k[0] ? 16'hffff : 16'(t);
         next_rise(1000, n);
         high_len(n);
         lo = (t + 2 > BLANK) ? t + 2 : BLANK;
         check(inr(n, lo, lo + 6), 32'h1);
      end
      sense_at <= 16'hffff;
      ilim_at <= 16'hffff;
      done("blanking");
      for (int r = 1; r < 5; r++)
      begin
         seed = xs(seed);
         t = (r < 4) ? r : 4 + int'(seed[1:0]);
         @(posedge clock);
         ri_kohm <= 6'(t);
         cyc(8);
         next_rise(1000, n);
         for (int j = 0; j < 4; j++)
         begin
            next_rise(1000, n);
            check(near(n, per(t)), 32'h1);
         end
      end
      done("frequency");
      fb_below_burst <= 1'b1;
      fb_on_request <= 1'b1;
      cyc(6);
      check({31'h0, burst_active}, 32'h1);
      rises(6000, n);
      check(n, 0);
      supply_below_preset <= 1'b1;
      next_rise(6000, n);
      next_rise(6000, n);
      check(near(n, int'(pfs_pkg::BURST_PER_CYC)), 32'h1);
      @(posedge clock);
      fb_on_request <= 1'b0;
      rises(6000, n);
      check(n, 0);
      fb_below_burst <= 1'b0;
      supply_below_preset <= 1'b0;
      done("burst");
      for (int k = 0; k < 6; k++)
      begin
         @(posedge clock);
         if (k < 4)
            pins[k] <= 1'b1;
         else if (k == 4)
            temp_below_otp <= 1'b1;
         else
            undervoltage_lockout_active <= 1'b1;
         cyc(5);
         check({31'h0, pin_fault | overtemp_fault}, {31'h0, k < 5});
         rises(300, n);
         check(n, 0);
         @(posedge clock);
         pins <= 4'h0;
         temp_below_otp <= 1'b0;
         undervoltage_lockout_active <= 1'b0;
         next_rise(3000, n);
         check(inr(n, SS, 2999), 32'h1);
      end
      done("protections");
      otp_latch_mode <= 1'b1;
      temp_below_otp <= 1'b1;
      cyc(20);
      temp_below_otp <= 1'b0;
      cyc(10);
      check({31'h0, latch_shutdown}, 32'h1);
      rises(2500, n);
      check(n, 0);
      supply_below_release <= 1'b1;
      cyc(10);
      check({31'h0, latch_shutdown}, 32'h0);
      supply_below_release <= 1'b0;
      otp_latch_mode <= 1'b0;
      next_rise(3000, n);
      check(inr(n, SS, 2999), 32'h1);
      done("latch");
      line_below_bo <= 1'b1;
      cyc(BO - 10);
      check({31'h0, brownout_fault}, 32'h0);
      cyc(20);
      check({31'h0, brownout_fault}, 32'h1);
      rises(300, n);
      check(n, 0);
      line_below_bo <= 1'b0;
      cyc(5);
      check({31'h0, brownout_fault}, 32'h0);
      next_rise(3000, n);
      check(inr(n, SS, 2999), 32'h1);
      done("brownout");
      overload_detect <= 1'b1;
      olp_wait(1'b1, n);
      check(inr(n, OVERLOAD_FAULT, OVERLOAD_FAULT + 6), 32'h1);
      olp_wait(1'b0, n);
      check(inr(n, RST - 1, RST + 1), 32'h1);
      olp_wait(1'b1, n);
      check(inr(n, OVERLOAD_FAULT, OVERLOAD_FAULT + 6), 32'h1);
      overload_detect <= 1'b0;
      olp_wait(1'b0, n);
      next_rise(4000, n);
      check(inr(n, SS, 3999), 32'h1);
      done("overload");
      tally_and_finish();
   end
endmodule
`default_nettype wire
